// ==== rtl/scr_map.svh ====
`ifndef SCR_MAP_SVH
`define SCR_MAP_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define SCR_ADDR_SCALE   6'h03
`define SCR_ADDR_DECAY   6'h04
`define SCR_ADDR_STEP    6'h05
`define SCR_ADDR_LOCK    6'h06
// ----------------------------------------
// Reset values
// ----------------------------------------
`define SCR_RST_SCALE    8'h00
`define SCR_RST_DECAY_LO 7'h0f
`define SCR_RST_STEP     8'h00
`define SCR_RST_LOCK     3'h3
// ----------------------------------------
// Field positions and codes
// ----------------------------------------
`define SCR_STEP_BIT     6
`define SCR_FLTCLR_BIT   7
`define SCR_LOCK_MSB     6
`define SCR_LOCK_LSB     4
`define SCR_LOCK_CODE    3'h6
`define SCR_UNLOCK_CODE  3'h3
`define SCR_RES_LAST     4'ha
`endif

// ==== rtl/scr_pkg.sv ====
package scr_pkg;
   // Decoded decay mode for the regulator
   typedef enum logic [2:0] {
      SCR_SLOW_SLOW, SCR_SLOW_MIX30, SCR_SLOW_MIX60, SCR_SLOW_FAST,
      SCR_MIX30_MIX30, SCR_MIX60_MIX60, SCR_ADAPT_DYN, SCR_ADAPT_RIPPLE
   } scr_decay_type;

   // Fields delivered to indexer and current regulator
   typedef struct packed {
      logic [3:0]    torque_scale;
      logic [1:0]    edge_rate;
      logic          outputs_hiz;
      logic [1:0]    chop_off_time;
      scr_decay_type decay;
      logic          dir_from_reg;
      logic          step_from_reg;
      logic          soft_dir;
      logic [3:0]    step_resolution;
   } scr_fields_type;

   // Register bank write/read request
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [5:0] addr;
      logic [7:0] wdata;
   } scr_req_type;
endpackage : scr_pkg

// ==== rtl/scr_lock.sv ====
`timescale 1ns/1ps
`include "scr_map.svh"
// Lock field keeper; gates writes to the control registers
module scr_lock
   import scr_pkg::*;
(
   input  wire logic        i_mclk,
   input  wire logic        i_rst_n,
   input  wire scr_req_type i_req,
   output logic [2:0]       o_lock,
   output logic             o_locked
);
   logic [2:0] lock;

   // ----------------------------------------
   // Lock field
   // ----------------------------------------
   // Only the two magic codes change state; others ignored
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         lock <= `SCR_RST_LOCK;
      end else if (i_req.wr && i_req.addr == `SCR_ADDR_LOCK) begin
         if (lock == `SCR_LOCK_CODE && i_req.wdata[`SCR_LOCK_MSB:`SCR_LOCK_LSB] == `SCR_UNLOCK_CODE) begin
            lock <= `SCR_UNLOCK_CODE;
         end else if (lock != `SCR_LOCK_CODE && i_req.wdata[`SCR_LOCK_MSB:`SCR_LOCK_LSB] == `SCR_LOCK_CODE) begin
            lock <= `SCR_LOCK_CODE;
         end
      end
   end

   assign o_lock   = lock;
   assign o_locked = (lock == `SCR_LOCK_CODE);
endmodule : scr_lock

// ==== rtl/scr_regs.sv ====
`timescale 1ns/1ps
`include "scr_map.svh"
module scr_regs
   import scr_pkg::*;
#(
   parameter logic HIZ_RESET = 1'b0
)
(
   input  wire logic            i_mclk,
   input  wire logic            i_rst_n,
   input  wire scr_req_type     i_req,
   input  wire logic            i_driver_off_pin,
   input  wire logic            i_dir_pin,
   input  wire logic            i_step_pin,
   output logic [7:0]           o_rdata,
   output logic                 o_rvalid,
   output scr_fields_type       o_fields,
   output logic                 o_bridge_hiz,
   output logic                 o_index_dir,
   output logic                 o_index_step,
   output logic [3:0]           o_index_resolution,
   output logic                 o_locked
);
   logic [3:0] torque_scale;
   logic [1:0] scale_rsvd;
   logic [1:0] edge_rate;
   logic       outputs_hiz;
   logic [1:0] decay_rsvd;
   logic [1:0] chop_off_time;
   logic [2:0] decay_code;
   logic       soft_dir;
   logic       soft_step;
   logic       dir_from_reg;
   logic       step_from_reg;
   logic [3:0] step_resolution;
   logic [2:0] lock;
   logic       locked;
   logic       wr_ok;

   // ----------------------------------------
   // Lock keeper
   // ----------------------------------------
   scr_lock u_lock (
      .i_mclk  (i_mclk),
      .i_rst_n (i_rst_n),
      .i_req   (i_req),
      .o_lock  (lock),
      .o_locked(locked)
   );

   assign wr_ok    = i_req.wr && !locked;
   assign o_locked = locked;

   // ----------------------------------------
   // Scale and edge-rate register
   // ----------------------------------------
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         {torque_scale, scale_rsvd, edge_rate} <= `SCR_RST_SCALE;
      end else if (wr_ok && i_req.addr == `SCR_ADDR_SCALE) begin
         {torque_scale, scale_rsvd, edge_rate} <= i_req.wdata;
      end
   end

   // ----------------------------------------
   // Hi-Z, off-time and decay register
   // ----------------------------------------
   // Hi-Z reset is a constant parameter, so async reset stays legal
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         outputs_hiz <= HIZ_RESET;
         {decay_rsvd, chop_off_time, decay_code} <= `SCR_RST_DECAY_LO;
      end else if (wr_ok && i_req.addr == `SCR_ADDR_DECAY) begin
         outputs_hiz <= i_req.wdata[7];
         {decay_rsvd, chop_off_time, decay_code} <= i_req.wdata[6:0];
      end
   end

   // ----------------------------------------
   // Step, direction and resolution register
   // ----------------------------------------
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         {soft_dir, soft_step, dir_from_reg, step_from_reg, step_resolution} <= `SCR_RST_STEP;
      end else if (wr_ok && i_req.addr == `SCR_ADDR_STEP) begin
         {soft_dir, soft_step, dir_from_reg, step_from_reg, step_resolution} <= i_req.wdata;
      end else begin
         soft_step <= 1'b0;
      end
   end

   // ----------------------------------------
   // Read-back
   // ----------------------------------------
   // Step bit reads as zero: it lives one cycle only
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_rdata  <= 8'h00;
         o_rvalid <= 1'b0;
      end else begin
         o_rvalid <= i_req.rd;
         unique case (i_req.addr)
            `SCR_ADDR_SCALE: o_rdata <= {torque_scale, scale_rsvd, edge_rate};
            `SCR_ADDR_DECAY: o_rdata <= {outputs_hiz, decay_rsvd, chop_off_time, decay_code};
            `SCR_ADDR_STEP:  o_rdata <= {soft_dir, 1'b0, dir_from_reg, step_from_reg, step_resolution};
            `SCR_ADDR_LOCK:  o_rdata <= {1'b0, lock, 4'h0};
            default:         o_rdata <= 8'h00;
         endcase
      end
   end

   // ----------------------------------------
   // Field outputs
   // ----------------------------------------
   // Straight from stored registers, so they change only on writes
   always_comb begin
      o_fields.torque_scale    = torque_scale;
      o_fields.edge_rate       = edge_rate;
      o_fields.outputs_hiz     = outputs_hiz;
      o_fields.chop_off_time   = chop_off_time;
      o_fields.decay           = scr_decay_type'(decay_code);
      o_fields.dir_from_reg    = dir_from_reg;
      o_fields.step_from_reg   = step_from_reg;
      o_fields.soft_dir        = soft_dir;
      o_fields.step_resolution = step_resolution;
   end

   // ----------------------------------------
   // Source selection towards indexer and bridge
   // ----------------------------------------
   assign o_bridge_hiz = outputs_hiz | i_driver_off_pin;
   assign o_index_dir  = dir_from_reg ? soft_dir : i_dir_pin;
   assign o_index_step = step_from_reg ? soft_step : i_step_pin;
   // Reserved codes fall back to full step for a deterministic indexer
   assign o_index_resolution = (step_resolution > `SCR_RES_LAST) ? 4'h0 : step_resolution;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   property p_step_one_pulse;
      @(posedge i_mclk) disable iff (!i_rst_n)
      (wr_ok && i_req.addr == `SCR_ADDR_STEP && i_req.wdata[`SCR_STEP_BIT] && i_req.wdata[4])
         |=> o_index_step ##1 (!o_index_step || $past(wr_ok));
   endproperty
   a_step_one_pulse: assert property (p_step_one_pulse) else $error("step pulse not one cycle");

   property p_step_clears;
      @(posedge i_mclk) disable iff (!i_rst_n)
      !(wr_ok && i_req.addr == `SCR_ADDR_STEP) |=> !soft_step;
   endproperty
   a_step_clears: assert property (p_step_clears) else $error("step bit did not clear");

   // Ties the written bit to the bridge, not just a copy of the OR
   property p_hiz_or;
      @(posedge i_mclk) disable iff (!i_rst_n)
      (wr_ok && i_req.addr == `SCR_ADDR_DECAY) |=> o_bridge_hiz == ($past(i_req.wdata[7]) || i_driver_off_pin);
   endproperty
   a_hiz_or: assert property (p_hiz_or) else $error("hi-z not OR of bit and pin");

   property p_locked_hold;
      @(posedge i_mclk) disable iff (!i_rst_n)
      (locked && i_req.wr && i_req.addr == `SCR_ADDR_SCALE) |=> $stable(o_fields.torque_scale);
   endproperty
   a_locked_hold: assert property (p_locked_hold) else $error("write accepted while locked");

   property p_scale_write;
      @(posedge i_mclk) disable iff (!i_rst_n)
      (wr_ok && i_req.addr == `SCR_ADDR_SCALE) |=> o_fields.torque_scale == $past(i_req.wdata[7:4]);
   endproperty
   a_scale_write: assert property (p_scale_write) else $error("scale write lost");

   property p_fields_stable;
      @(posedge i_mclk) disable iff (!i_rst_n)
      !wr_ok |=> $stable(o_fields.decay) && $stable(o_fields.step_resolution) && $stable(o_fields.edge_rate);
   endproperty
   a_fields_stable: assert property (p_fields_stable) else $error("field moved without write");

   property p_dir_select;
      @(posedge i_mclk) disable iff (!i_rst_n)
      (wr_ok && i_req.addr == `SCR_ADDR_STEP && i_req.wdata[5]) |=> o_index_dir == $past(i_req.wdata[7]);
   endproperty
   a_dir_select: assert property (p_dir_select) else $error("direction source wrong");

   property p_step_res_write;
      @(posedge i_mclk) disable iff (!i_rst_n)
      (wr_ok && i_req.addr == `SCR_ADDR_STEP) |=> o_fields.step_resolution == $past(i_req.wdata[3:0]);
   endproperty
   a_step_res_write: assert property (p_step_res_write) else $error("resolution write lost");

   property p_res_fallback;
      @(posedge i_mclk) disable iff (!i_rst_n)
      (o_fields.step_resolution > `SCR_RES_LAST) |-> o_index_resolution == 4'h0;
   endproperty
   a_res_fallback: assert property (p_res_fallback) else $error("reserved resolution not full step");

   property p_read_two;
      @(posedge i_mclk) disable iff (!i_rst_n)
      (i_req.rd && i_req.addr == `SCR_ADDR_DECAY) |=> o_rvalid && o_rdata[2:0] == $past(decay_code);
   endproperty
   a_read_two: assert property (p_read_two) else $error("decay read-back wrong");

   c_soft_step:  cover property (@(posedge i_mclk) disable iff (!i_rst_n) o_index_step && step_from_reg);
   c_lock:       cover property (@(posedge i_mclk) disable iff (!i_rst_n) $rose(locked));
   c_unlock:     cover property (@(posedge i_mclk) disable iff (!i_rst_n) $fell(locked));
   c_adapt_dyn:  cover property (@(posedge i_mclk) disable iff (!i_rst_n) o_fields.decay == SCR_ADAPT_DYN);
endmodule : scr_regs

// ==== verification/scr_host.sv ====
`timescale 1ns/1ps
// Host side of the configuration port: one-cycle request strobes
module scr_host
   import scr_pkg::*;
(
   input  wire logic        i_mclk,
   input  wire logic [7:0]  i_rdata,
   input  wire logic        i_rvalid,
   output scr_req_type      o_req
);
   // Idle bus from time zero
   initial o_req = '0;

   // Strobe for one edge, then sample the answer mid-cycle
   task automatic xfer(input logic w, input logic [5:0] a, input logic [7:0] d,
                       output logic [7:0] q, output logic v);
      @(posedge i_mclk);
      o_req <= '{wr: w, rd: !w, addr: a, wdata: d};
      @(posedge i_mclk);
      o_req <= '0;
      @(negedge i_mclk);
      q = i_rdata;
      v = i_rvalid;
   endtask : xfer
endmodule : scr_host

// ==== verification/test_stepper_control_registers.sv ====
`timescale 1ns/1ps
module test_stepper_control_registers
   import scr_pkg::*;
;
   logic           i_mclk = 1'b0;
   logic           i_rst_n = 1'b0;
   logic           drv_off = 1'b0;
   logic           dir_pin = 1'b0;
   logic           step_pin = 1'b0;
   scr_req_type    req;
   logic [7:0]     rdata;
   logic           rvalid;
   scr_fields_type fields;
   logic           hiz;
   logic           idir;
   logic           istep;
   logic [3:0]     ires;
   logic           locked;
   logic [7:0]     alt_rdata;
   scr_fields_type alt_fields;
   logic           alt_hiz;
   int             bad_count = 0;
   int             comparisons = 0;
   // Rows: address, write data, expected readback
   logic [21:0]    rows [8] = '{{6'h03, 8'hff, 8'hff}, {6'h03, 8'ha5, 8'ha5}, {6'h04, 8'hff, 8'hff},
                                {6'h04, 8'h6a, 8'h6a}, {6'h05, 8'hff, 8'hbf}, {6'h05, 8'hab, 8'hab},
                                {6'h05, 8'h0b, 8'h0b}, {6'h07, 8'h55, 8'h00}};

   // Free-running 10 MHz clock
   always #50 i_mclk = ~i_mclk;

   scr_host host (.i_mclk(i_mclk), .i_rdata(rdata), .i_rvalid(rvalid), .o_req(req));

   scr_regs #(.HIZ_RESET(1'b0)) dut (
      .i_mclk             (i_mclk),
      .i_rst_n            (i_rst_n),
      .i_req              (req),
      .i_driver_off_pin   (drv_off),
      .i_dir_pin          (dir_pin),
      .i_step_pin         (step_pin),
      .o_rdata            (rdata),
      .o_rvalid           (rvalid),
      .o_fields           (fields),
      .o_bridge_hiz       (hiz),
      .o_index_dir        (idir),
      .o_index_step       (istep),
      .o_index_resolution (ires),
      .o_locked           (locked)
   );

   // Alternate variant: outputs come up in Hi-Z
   scr_regs #(.HIZ_RESET(1'b1)) dut_alt (
      .i_mclk             (i_mclk),
      .i_rst_n            (i_rst_n),
      .i_req              (req),
      .i_driver_off_pin   (drv_off),
      .i_dir_pin          (dir_pin),
      .i_step_pin         (step_pin),
      .o_rdata            (alt_rdata),
      .o_rvalid           (),
      .o_fields           (alt_fields),
      .o_bridge_hiz       (alt_hiz),
      .o_index_dir        (),
      .o_index_step       (),
      .o_index_resolution (),
      .o_locked           ()
   );

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic chk(input string n, input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", n, exp, got);
      end
   endtask : chk

   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      logic [7:0] q;
      logic       v;
      host.xfer(1'b1, a, d, q, v);
   endtask : wr

   // Readback also demands that valid is high when the data is sampled
   task automatic rd_chk(input string n, input logic [5:0] a, input logic [7:0] e);
      logic [7:0] q;
      logic       v;
      host.xfer(1'b0, a, 8'h00, q, v);
      chk(n, q, e);
      chk("rvalid", {7'h0, v}, 8'h01);
   endtask : rd_chk

   task automatic test_done();
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : test_done

   // Watchdog, far beyond the roughly 126 cycles the tests need
   initial begin
      #1_000_000;
      bad_count++;
      test_done();
   end

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      repeat (4) @(posedge i_mclk);
      i_rst_n <= 1'b1;
      rd_chk("scale reset", 6'h03, 8'h00);
      rd_chk("decay reset", 6'h04, 8'h0f);
      chk("alt decay reset", alt_rdata, 8'h8f);
      rd_chk("step reset", 6'h05, 8'h00);
      chk("hiz reset", {7'h0, hiz}, 8'h00);
      chk("alt hiz reset", {7'h0, alt_hiz}, 8'h01);
      foreach (rows[i]) begin
         wr(rows[i][21:16], rows[i][15:8]);
         rd_chk("readback", rows[i][21:16], rows[i][7:0]);
      end
      // Every decay and resolution code, reserved ones included
      for (int c = 0; c < 8; c++) begin
         wr(6'h04, 8'h08 | c[7:0]);
         chk("decay", 8'(fields.decay), c[7:0]);
      end
      for (int c = 0; c < 16; c++) begin
         wr(6'h05, c[7:0]);
         chk("resolution", {4'h0, ires}, (c < 11) ? c[7:0] : 8'h00);
      end
      // Hi-Z from the bit and from the pin
      wr(6'h04, 8'h80);
      chk("hiz bit", {7'h0, hiz}, 8'h01);
      wr(6'h04, 8'h00);
      chk("hiz clear", {7'h0, hiz}, 8'h00);
      @(posedge i_mclk) drv_off <= 1'b1;
      @(negedge i_mclk) chk("hiz pin", {7'h0, hiz}, 8'h01);
      // Pin sources first, then register sources
      @(posedge i_mclk) begin
         dir_pin <= 1'b1;
         step_pin <= 1'b1;
      end
      @(negedge i_mclk) chk("dir pin", {7'h0, idir}, 8'h01);
      chk("step pin", {7'h0, istep}, 8'h01);
      @(posedge i_mclk) step_pin <= 1'b0;
      wr(6'h05, 8'h20);
      chk("soft dir 0", {7'h0, idir}, 8'h00);
      wr(6'h05, 8'ha0);
      chk("soft dir 1", {7'h0, idir}, 8'h01);
      wr(6'h05, 8'h50);
      chk("step pulse", {7'h0, istep}, 8'h01);
      @(negedge i_mclk) chk("step ends", {7'h0, istep}, 8'h00);
      // Lock blocks writes, other codes are ignored, unlock restores
      wr(6'h06, 8'h60);
      chk("locked", {7'h0, locked}, 8'h01);
      wr(6'h03, 8'h12);
      wr(6'h06, 8'h10);
      rd_chk("scale locked", 6'h03, 8'ha5);
      wr(6'h06, 8'h30);
      chk("unlocked", {7'h0, locked}, 8'h00);
      wr(6'h03, 8'h12);
      rd_chk("scale open", 6'h03, 8'h12);
      // Reset mid-run while locked: defaults and the open lock come back
      wr(6'h06, 8'h60);
      @(posedge i_mclk) i_rst_n <= 1'b0;
      @(posedge i_mclk) i_rst_n <= 1'b1;
      @(negedge i_mclk) chk("lock reset", {7'h0, locked}, 8'h00);
      chk("alt hiz bit reset", {7'h0, alt_fields.outputs_hiz}, 8'h01);
      rd_chk("scale reset 2", 6'h03, 8'h00);
      rd_chk("step reset 2", 6'h05, 8'h00);
      test_done();
   end
endmodule : test_stepper_control_registers
